// ---- common/mcsc_pkg.sv ----
// constants, types and helpers of the carrier slot configuration block
//
// Notes on behaviour
// R1 - sequential start address: any multiple of 8
// R2 - sequential: next locations count up by one
// R3 - modulo-8: start multiple of 64, step 8; the start is taken as any multiple of 8 in this mode too
// R4 - disabled location keeps slot, never answers
// R5 - start address is sum of open weights
// R6 - position 8 open A16/A24, closed A16/A32
// R7 - slot switch open disables, closed enables
// R8 - default required memory: 512 B or 64 KB
// R9 - extended window blocked until access bit set
// R10 - I/O low 256 bytes, memory upper half
// R11 - controller programs twice module memory size
// R12 - device type write stores required memory only
// R13 - new required memory waits for power-up
// R14 - ready clear during storage write, then set
// R15 - identifying module sets required memory itself
// R16 - per-location trigger register picks TTL lines
// R17 - each channel enabled and directed independently
// R18 - per-channel inversion of passed level
// R19 - several modules may share one line
// R20 - line select 0 to 7, default 0
// R21 - direction 0 input, 1 output; defaults off
// R22 - access bit 0 blocks extended access
// R23 - disabled or input channel never drives line
package mcsc_pkg;

  // ---------------------------------------------------------------
  // geometry and timing
  // ---------------------------------------------------------------
  localparam int NUM_LOC      = 6;
  localparam int NUM_TTL      = 8;
  localparam int CLK_PERIOD_NS = 5;
  localparam int NV_WRITE_NS  = 5000;   // storage write busy time
  localparam int NV_WRITE_CYC =
    (NV_WRITE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [1:0] SETTLE_CYC = 2'h3; // synchroniser fill

  // ---------------------------------------------------------------
  // register offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] OFS_DEVTYPE  = 8'h02;
  localparam logic [7:0] OFS_STATUS   = 8'h04;
  localparam logic [7:0] OFS_OFFSET   = 8'h06;
  localparam logic [7:0] OFS_TRIG     = 8'h0A;
  localparam logic [7:0] OFS_TRIG_ALT = 8'h22;

  // ---------------------------------------------------------------
  // fields and reset values
  // ---------------------------------------------------------------
  localparam int REQMEM_LSB   = 12;
  localparam int STAT_ACCESS  = 15;
  localparam int STAT_READY   = 3;
  localparam logic [15:0] STAT_FIXED = 16'h7FF4; // id, csum, pass
  localparam logic [3:0]  REQMEM_A24_MIN = 4'hE;  // 512 bytes
  localparam logic [3:0]  REQMEM_A32_MIN = 4'hF;  // 64 Kbytes
  localparam logic [11:0] MODEL_CODE = 12'h0A5;   // arbitrary value
  localparam int TRG_STRIDE   = 8;
  localparam int TRG_EN       = 7;
  localparam int TRG_DIR      = 6;
  localparam int TRG_INV      = 5;
  localparam logic [15:0] TRG_WMASK = 16'hE7E7;
  localparam logic [15:0] TRG_RESET = 16'h0000;
  localparam logic [4:0]  WIN_A24_EXP = 5'h17;   // size 2^(23-m)
  localparam logic [4:0]  WIN_A32_EXP = 5'h1F;   // size 2^(31-m)
  localparam logic [31:0] IO_SPAN    = 32'h0000_0100;

  // ---------------------------------------------------------------
  // start-up phases
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    PH_SETTLE = 3'h1,
    PH_LOAD   = 3'h2,
    PH_RUN    = 3'h4
  } mcsc_phase_t;

  // logical address of a location from the start address
  function automatic logic [7:0] mcsc_la(input logic [7:0] start,
                                         input logic [2:0] idx,
                                         input logic       mod8);
    if (mod8) begin
      return start + {2'h0, idx, 3'h0};
    end
    return start + {5'h00, idx};
  endfunction : mcsc_la

endpackage : mcsc_pkg

// ---- src/mcsc_window_decode.sv ----
// window decode of one location in the A24/A32 space
`timescale 1ns/100ps
module mcsc_window_decode (
  input  wire logic [15:0] offset,
  input  wire logic [3:0]  memCode,
  input  wire logic        a32Mode,
  input  wire logic        allow,
  input  wire logic [31:0] addr,
  output logic             hit,
  output logic             isIo,
  output logic             isMem,
  output logic [31:0]      rel
);
  import mcsc_pkg::*;

  logic [4:0]  shamt;
  logic [31:0] size;
  logic [31:0] base;

  // window base and size from offset and required-memory code
  always_comb begin
    shamt = a32Mode ? WIN_A32_EXP - {1'b0, memCode}
                    : WIN_A24_EXP - {1'b0, memCode};
    size  = 32'h0000_0001 << shamt;
    base  = a32Mode ? {offset, 16'h0000} : {8'h00, offset, 8'h00};
    rel   = addr - base;
    hit   = allow && (addr >= base) && (rel < size); // R9 R22
    isIo  = hit && (rel < IO_SPAN);                  // R10
    isMem = hit && (rel >= (size >> 1));             // R10
  end

endmodule : mcsc_window_decode

// ---- src/mcsc_slot_config.sv ----
// carrier slot configuration: addresses, registers, trigger routing
`timescale 1ns/100ps
module mcsc_slot_config (
  input  wire logic                              sys_clk,
  input  wire logic                              rst,
  input  wire logic [7:0]                        laSwitch,
  input  wire logic                              moduloSelect,
  input  wire logic [mcsc_pkg::NUM_LOC-1:0]      slotSwitch,
  input  wire logic [mcsc_pkg::NUM_LOC-1:0]      identValid,
  input  wire logic [4*mcsc_pkg::NUM_LOC-1:0]    identReqMem,
  input  wire logic [2:0]                        regLoc,
  input  wire logic [7:0]                        regAddr,
  input  wire logic                              regWr,
  input  wire logic                              regRd,
  input  wire logic [15:0]                       regWrData,
  output logic [15:0]                            regRdData,
  output logic                                   regAck,
  input  wire logic [7:0]                        a16Addr,
  output logic [mcsc_pkg::NUM_LOC-1:0]           a16Hit,
  input  wire logic [31:0]                       extAddr,
  output logic [mcsc_pkg::NUM_LOC-1:0]           extHit,
  output logic                                   extIsIo,
  output logic                                   extIsMem,
  output logic [31:0]                            extRel,
  input  wire logic [mcsc_pkg::NUM_TTL-1:0]      ttlTrigIn,
  output logic [mcsc_pkg::NUM_TTL-1:0]           ttlTrigOut,
  output logic [mcsc_pkg::NUM_TTL-1:0]           ttlTrigOe,
  input  wire logic [2*mcsc_pkg::NUM_LOC-1:0]    modTrigOut,
  output logic [2*mcsc_pkg::NUM_LOC-1:0]         modTrigIn,
  output logic                                   nvReady,
  output logic                                   configDone
);
  import mcsc_pkg::*;

  // -----------------------------------------------------------------
  // state
  // -----------------------------------------------------------------
  typedef struct packed {
    logic [7:0]                 laS1;
    logic [7:0]                 laS2;
    logic                       modS1;
    logic                       modS2;
    logic [NUM_LOC-1:0]         slotS1;
    logic [NUM_LOC-1:0]         slotS2;
    logic [NUM_TTL-1:0]         ttlS1;
    logic [NUM_TTL-1:0]         ttlS2;
    logic [2*NUM_LOC-1:0]       toS1;
    logic [2*NUM_LOC-1:0]       toS2;
    mcsc_phase_t                phase;
    logic [1:0]                 settleCnt;
    logic [7:0]                 startLa;
    logic                       mod8;
    logic                       a32;
    logic [NUM_LOC-1:0]         enabled;
    logic [NUM_LOC-1:0][3:0]    nvMem;
    logic [NUM_LOC-1:0][3:0]    actMem;
    logic [NUM_LOC-1:0]         access;
    logic [NUM_LOC-1:0][15:0]   offs;
    logic [NUM_LOC-1:0][15:0]   trig;
    logic [15:0]                nvCnt;
    logic                       ready;
    logic [15:0]                rdData;
    logic                       ack;
    logic [NUM_LOC-1:0]         a16Hit;
    logic [NUM_LOC-1:0]         extHit;
    logic                       extIo;
    logic                       extMem;
    logic [31:0]                extRel;
    logic [NUM_TTL-1:0]         ttlOut;
    logic [NUM_TTL-1:0]         ttlOe;
    logic [2*NUM_LOC-1:0]       trigIn;
  } mcsc_state_t;

  mcsc_state_t stFf;
  mcsc_state_t nxt_st;

  logic [NUM_LOC-1:0]         winHit;
  logic [NUM_LOC-1:0]         winIo;
  logic [NUM_LOC-1:0]         winMem;
  logic [NUM_LOC-1:0][31:0]   winRel;

  // -----------------------------------------------------------------
  // one window decoder per location
  // -----------------------------------------------------------------
  for (genvar g = 0; g < NUM_LOC; g++) begin : gWin
    mcsc_window_decode uWin (
      .offset  (stFf.offs[g]),
      .memCode (stFf.actMem[g]),
      .a32Mode (stFf.a32),
      .allow   (stFf.access[g] && stFf.enabled[g]),
      .addr    (extAddr),
      .hit     (winHit[g]),
      .isIo    (winIo[g]),
      .isMem   (winMem[g]),
      .rel     (winRel[g])
    );
  end

  // -----------------------------------------------------------------
  // next-state logic
  // -----------------------------------------------------------------
  always_comb begin
    logic [7:0] f;
    logic       lvl;
    logic       loc_ok;
    int         li;
    f      = 8'h00;
    lvl    = 1'b0;
    loc_ok = 1'b0;
    li     = 0;
    nxt_st = stFf;

    // two-stage synchronisers on pins
    nxt_st.laS1   = laSwitch;
    nxt_st.laS2   = stFf.laS1;
    nxt_st.modS1  = moduloSelect;
    nxt_st.modS2  = stFf.modS1;
    nxt_st.slotS1 = slotSwitch;
    nxt_st.slotS2 = stFf.slotS1;
    nxt_st.ttlS1  = ttlTrigIn;
    nxt_st.ttlS2  = stFf.ttlS1;
    nxt_st.toS1   = modTrigOut;
    nxt_st.toS2   = stFf.toS1;

    // start-up: wait for syncs, capture switches and memory codes
    unique case (stFf.phase)
      PH_SETTLE: begin
        if (stFf.settleCnt == SETTLE_CYC) begin
          nxt_st.phase = PH_LOAD;
        end else begin
          nxt_st.settleCnt = stFf.settleCnt + 2'h1;
        end
      end
      PH_LOAD: begin
        nxt_st.startLa = {stFf.laS2[0], stFf.laS2[1], stFf.laS2[2],
                          stFf.laS2[3], stFf.laS2[4], 3'h0};   // R5 R1 R3
        nxt_st.mod8    = stFf.modS2;
        nxt_st.a32     = ~stFf.laS2[7];                         // R6
        nxt_st.enabled = ~stFf.slotS2;                          // R7
        for (int l = 0; l < NUM_LOC; l++) begin
          if (identValid[l]) begin
            nxt_st.nvMem[l] = identReqMem[4*l +: 4];            // R15
          end else if (stFf.laS2[7]) begin
            nxt_st.nvMem[l] = REQMEM_A24_MIN;                   // R8
          end else begin
            nxt_st.nvMem[l] = REQMEM_A32_MIN;                   // R8
          end
          nxt_st.actMem[l] = nxt_st.nvMem[l];
        end
        nxt_st.phase = PH_RUN;
      end
      PH_RUN: begin
        nxt_st.phase = PH_RUN;
      end
    endcase

    // storage write countdown
    if (stFf.nvCnt != 16'h0000) begin
      nxt_st.nvCnt = stFf.nvCnt - 16'h0001;
    end

    // register access, one answer per strobe
    li     = int'(regLoc);
    loc_ok = (regLoc < 3'(NUM_LOC)) && (stFf.phase == PH_RUN);
    nxt_st.ack    = (regWr || regRd) && (stFf.phase == PH_RUN);
    nxt_st.rdData = 16'h0000;
    if (loc_ok && regWr) begin
      unique case (regAddr)
        OFS_DEVTYPE: begin
          if (stFf.ready) begin
            // model code bits dropped; active code untouched
            nxt_st.nvMem[li] = regWrData[REQMEM_LSB +: 4];  // R12 R13
            nxt_st.nvCnt     = 16'(NV_WRITE_CYC);           // R14
          end
        end
        OFS_STATUS:   nxt_st.access[li] = regWrData[STAT_ACCESS]; // R9
        OFS_OFFSET:   nxt_st.offs[li]   = regWrData;
        OFS_TRIG,
        OFS_TRIG_ALT: nxt_st.trig[li]   = regWrData & TRG_WMASK; // R16
        default: ;
      endcase
    end else if (loc_ok && regRd) begin
      unique case (regAddr)
        OFS_DEVTYPE:  nxt_st.rdData = {stFf.nvMem[li], MODEL_CODE};
        OFS_STATUS: begin
          nxt_st.rdData = STAT_FIXED;
          nxt_st.rdData[STAT_ACCESS] = stFf.access[li];
          nxt_st.rdData[STAT_READY]  = stFf.ready;          // R14
        end
        OFS_OFFSET:   nxt_st.rdData = stFf.offs[li];
        OFS_TRIG,
        OFS_TRIG_ALT: nxt_st.rdData = stFf.trig[li];
        default:      nxt_st.rdData = 16'h0000;
      endcase
    end
    nxt_st.ready = (nxt_st.nvCnt == 16'h0000) && (stFf.phase == PH_RUN);

    // A16 decode: disabled locations keep their slot but stay silent
    for (int l = 0; l < NUM_LOC; l++) begin
      nxt_st.a16Hit[l] = (stFf.phase == PH_RUN) && stFf.enabled[l] &&
        (a16Addr == mcsc_la(stFf.startLa, 3'(l), stFf.mod8)); // R2 R3 R4
    end

    // extended space decode, lowest hitting location reported
    nxt_st.extHit = winHit;
    nxt_st.extIo  = 1'b0;
    nxt_st.extMem = 1'b0;
    nxt_st.extRel = 32'h0000_0000;
    for (int l = NUM_LOC - 1; l >= 0; l--) begin
      if (winHit[l]) begin
        nxt_st.extIo  = winIo[l];                           // R10
        nxt_st.extMem = winMem[l];
        nxt_st.extRel = winRel[l];
      end
    end

    // trigger routing; shared lines are or-combined
    nxt_st.ttlOut = '0;
    nxt_st.ttlOe  = '0;
    nxt_st.trigIn = '0;
    for (int c = 0; c < 2 * NUM_LOC; c++) begin
      f = stFf.trig[c / 2][(c % 2) * TRG_STRIDE +: TRG_STRIDE];
      if (f[TRG_EN] && !f[TRG_DIR]) begin                    // R17 R21
        lvl = stFf.ttlS2[f[2:0]] ^ f[TRG_INV];               // R18 R20
        nxt_st.trigIn[c] = lvl;
      end else if (f[TRG_EN] && f[TRG_DIR]) begin            // R23
        lvl = stFf.toS2[c] ^ f[TRG_INV];                     // R18
        nxt_st.ttlOe[f[2:0]]  = 1'b1;                        // R19
        nxt_st.ttlOut[f[2:0]] = nxt_st.ttlOut[f[2:0]] | lvl;
      end
    end
  end

  // -----------------------------------------------------------------
  // state register
  // -----------------------------------------------------------------
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      stFf       <= '0;
      stFf.phase <= PH_SETTLE;
      for (int l = 0; l < NUM_LOC; l++) begin
        stFf.trig[l] <= TRG_RESET;                           // R20 R21
      end
    end else begin
      stFf <= nxt_st;
    end
  end

  // outputs straight from the state register
  assign regRdData  = stFf.rdData;
  assign regAck     = stFf.ack;
  assign a16Hit     = stFf.a16Hit;
  assign extHit     = stFf.extHit;
  assign extIsIo    = stFf.extIo;
  assign extIsMem   = stFf.extMem;
  assign extRel     = stFf.extRel;
  assign ttlTrigOut = stFf.ttlOut;
  assign ttlTrigOe  = stFf.ttlOe;
  assign modTrigIn  = stFf.trigIn;
  assign nvReady    = stFf.ready;
  assign configDone = stFf.phase[2]; // one-hot run state bit

  // -----------------------------------------------------------------
  // assertions
  // -----------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  logic devWrOk;
  assign devWrOk = regWr && (regAddr == OFS_DEVTYPE) && stFf.ready &&
                   (regLoc < 3'(NUM_LOC)) && (stFf.phase == PH_RUN);

  a_nv_busy_ready: assert property ( // R14
    devWrOk |=> !nvReady [*8])
    else $error("ready not cleared during storage write");

  a_nv_ready_back: assert property ( // R14
    (stFf.nvCnt == 16'h0001) |=> nvReady)
    else $error("ready not restored after storage write");

  a_nv_store: assert property ( // R12
    devWrOk |=> stFf.nvMem[$past(regLoc)] ==
                $past(regWrData[15:12]))
    else $error("required memory field not stored");

  a_act_frozen: assert property ( // R13
    (stFf.phase == PH_RUN) |=> $stable(stFf.actMem))
    else $error("active memory code changed while running");

  a_ext_gate: assert property ( // R9
    (extHit & ~$past(stFf.access)) == '0)
    else $error("extended hit without access enable");

  a_a16_disabled: assert property ( // R4
    (a16Hit & ~$past(stFf.enabled)) == '0)
    else $error("disabled location answered");

  a_la_sequence: assert property ( // R2
    (stFf.phase == PH_RUN) && !stFf.mod8 && stFf.enabled[1] &&
    (a16Addr == stFf.startLa + 8'h01) |=> a16Hit[1])
    else $error("location B missed its sequential address");

  a_trig_idle: assert property ( // R23
    !stFf.trig[0][TRG_EN] && !stFf.trig[0][TRG_STRIDE + TRG_EN] &&
    (stFf.trig[NUM_LOC-1:1] == '0) |=> (ttlTrigOe == '0))
    else $error("line driven with no output channel");

  a_trig_drive: assert property ( // R16
    stFf.trig[0][TRG_EN] && stFf.trig[0][TRG_DIR] |=>
    ttlTrigOe[$past(stFf.trig[0][2:0])])
    else $error("output channel did not drive its line");

  a_la_modulo: assert property ( // R3
    (stFf.phase == PH_RUN) && stFf.mod8 && stFf.enabled[2] &&
    (a16Addr == stFf.startLa + 8'h10) |=> a16Hit[2])
    else $error("location C missed its modulo-8 address");

  a_space_switch: assert property ( // R6
    (stFf.phase == PH_LOAD) |=> (stFf.a32 == !$past(stFf.laS2[7])))
    else $error("address space not taken from position 8");

  a_trig_in_off: assert property ( // R17
    (!stFf.trig[0][TRG_EN] || stFf.trig[0][TRG_DIR]) |=> !modTrigIn[0])
    else $error("module input fed by an idle channel");

  // level that channel B of location A must hand to its module
  logic chanBLvl;
  assign chanBLvl = stFf.ttlS2[stFf.trig[0][TRG_STRIDE +: 3]] ^
                    stFf.trig[0][TRG_STRIDE + TRG_INV];

  a_trig_invert: assert property ( // R18
    stFf.trig[0][TRG_STRIDE + TRG_EN] &&
    !stFf.trig[0][TRG_STRIDE + TRG_DIR] |=> modTrigIn[1] == $past(chanBLvl))
    else $error("input channel level not passed as set");

  a_io_low_span: assert property ( // R10
    extIsIo |-> (extHit != '0) && (extRel < IO_SPAN))
    else $error("I/O access outside the low 256 bytes");

  c_nv_write: cover property (devWrOk ##1 !nvReady);
  c_ext_io:   cover property (extIsIo && extHit != '0);
  c_ext_mem:  cover property (extIsMem && extHit != '0);
  c_ttl_out:  cover property (ttlTrigOe != '0);

endmodule : mcsc_slot_config

// ---- testbench/mcsc_ctrl_model.sv ----
// controller model: register side of the backplane resource manager
`timescale 1ns/100ps
module mcsc_ctrl_model (
  input  wire logic        sys_clk,
  input  wire logic        nvReady,
  input  wire logic        regAck,
  input  wire logic [15:0] regRdData,
  output logic [2:0]       regLoc,
  output logic [7:0]       regAddr,
  output logic             regWr,
  output logic             regRd,
  output logic [15:0]      regWrData
);
  import mcsc_pkg::*;

  // idle bus at time zero
  initial begin
    regLoc    = 3'h0;
    regAddr   = 8'h00;
    regWr     = 1'b0;
    regRd     = 1'b0;
    regWrData = 16'h0000;
  end

  // one strobe, then a bounded wait for the acknowledge
  task automatic access(input logic wr, input logic [2:0] loc,
                        input logic [7:0] adr, input logic [15:0] dat,
                        output logic [15:0] rd, output logic ok);
    int   n;
    logic rdy;
    ok = 1'b0;
    rd = 16'h0000;
    // keep off the device type while its store is busy
    for (n = 0; n < 1500 && adr == OFS_DEVTYPE && nvReady !== 1'b1;
         n++) begin
      @(posedge sys_clk);
    end
    // a wait that ran out fails the access
    rdy = (adr != OFS_DEVTYPE) || (nvReady === 1'b1);
    @(posedge sys_clk);
    regLoc    <= loc;
    regAddr   <= adr;
    regWrData <= dat;
    regWr     <= wr;
    regRd     <= ~wr;
    @(posedge sys_clk);
    regWr     <= 1'b0;
    regRd     <= 1'b0;
    regAddr   <= ~adr;  // released lines carry no stale value
    regWrData <= ~dat;
    for (n = 0; n < 4 && !ok; n++) begin
      @(posedge sys_clk);
      ok = (regAck === 1'b1);
      rd = regRdData;
    end
    ok = ok && rdy;
  endtask : access

  // required memory: twice the module memory, never below the minimum
  task automatic set_reqmem(input logic [2:0] loc, input int modBytes,
                            input logic a32, output logic ok);
    int          m;
    logic [15:0] rd;
    m = (a32 ? 31 : 23) - $clog2(2 * modBytes);
    m = (m > (a32 ? 15 : 14)) ? (a32 ? 15 : 14) : m;
    access(1'b1, loc, OFS_DEVTYPE, {4'(m), 12'h5A5}, rd, ok);
  endtask : set_reqmem
endmodule : mcsc_ctrl_model

// ---- testbench/module_carrier_slot_config_test.sv ----
// self-checking bench of the carrier slot configuration block
`timescale 1ns/100ps
module module_carrier_slot_config_test;
  import mcsc_pkg::*;

  logic        sys_clk, rst, moduloSelect, regWr, regRd, regAck;
  logic        extIsIo, extIsMem, nvReady, configDone;
  logic [2:0]  regLoc;
  logic [5:0]  slotSwitch, identValid, a16Hit, extHit;
  logic [7:0]  laSwitch, regAddr, a16Addr, bpLine;
  logic [7:0]  ttlTrigIn, ttlTrigOut, ttlTrigOe;
  logic [11:0] modTrigOut, modTrigIn;
  logic [15:0] regWrData, regRdData;
  logic [23:0] identReqMem;
  logic [31:0] extAddr, extRel;
  int          badCount;
  int          totalChecks;

  // backplane lines: the block's drive wins where it is enabled
  assign ttlTrigIn = (ttlTrigOe & ttlTrigOut) | (~ttlTrigOe & bpLine);

  mcsc_slot_config u_dut (
    .sys_clk, .rst, .laSwitch, .moduloSelect, .slotSwitch, .identValid,
    .identReqMem, .regLoc, .regAddr, .regWr, .regRd, .regWrData,
    .regRdData, .regAck, .a16Addr, .a16Hit, .extAddr, .extHit, .extIsIo,
    .extIsMem, .extRel, .ttlTrigIn, .ttlTrigOut, .ttlTrigOe,
    .modTrigOut, .modTrigIn, .nvReady, .configDone
  );

  mcsc_ctrl_model u_ctrl (
    .sys_clk, .nvReady, .regAck, .regRdData, .regLoc, .regAddr, .regWr,
    .regRd, .regWrData
  );

  // 200 MHz clock
  always #2.5 sys_clk = ~sys_clk;

  // compare and count
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    totalChecks++;
    if (got !== exp) begin
      badCount++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  // verdict and end of run
  task automatic conclude();
    if (badCount == 0 && totalChecks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : conclude

  // reset with new switch settings, bounded wait for start-up
  task automatic boot(input logic [7:0] sw, input logic mod8,
                      input logic [5:0] slots);
    int n;
    @(posedge sys_clk);
    rst          <= 1'b1;
    laSwitch     <= sw;
    moduloSelect <= mod8;
    slotSwitch   <= slots;
    repeat (2) @(posedge sys_clk);
    rst <= 1'b0;
    for (n = 0; n < 20 && configDone !== 1'b1; n++) begin
      @(posedge sys_clk);
    end
    if (configDone !== 1'b1) begin
      badCount++;
      conclude();
    end
  endtask : boot

  // register access; for reads dat is the expected value
  task automatic xfer(input logic wr, input logic [2:0] loc,
                      input logic [7:0] adr, input logic [15:0] dat);
    logic [15:0] rd;
    logic        ok;
    u_ctrl.access(wr, loc, adr, dat, rd, ok);
    check({15'h0, ok, wr ? dat : rd}, {16'h0001, dat});
  endtask : xfer

  // query every logical address of the carrier and one beyond
  task automatic a16_chk(input logic [7:0] sw, input logic mod8,
                         input logic [5:0] slots);
    logic [5:0] exp;
    logic [7:0] s;
    int         l;
    s = {sw[0], sw[1], sw[2], sw[3], sw[4], 3'h0};
    for (l = 0; l < 7; l++) begin
      exp = 6'h00;
      if (l < 6) begin
        exp[l] = ~slots[l];
      end
      @(posedge sys_clk);
      a16Addr <= mod8 ? s + 8'(8 * l) : s + 8'(l);
      repeat (2) @(posedge sys_clk);
      check(32'(a16Hit), 32'(exp));
    end
  endtask : a16_chk

  // one extended address and its decode
  task automatic ext_chk(input logic [31:0] adr, input logic [5:0] hit,
                         input logic io, input logic mem,
                         input logic [31:0] rel);
    @(posedge sys_clk);
    extAddr <= adr;
    repeat (2) @(posedge sys_clk);
    check(32'(extHit), 32'(hit));
    if (hit != 6'h00) begin
      check({30'h0, extIsIo, extIsMem}, {30'h0, io, mem});
      check(extRel, rel);
    end
  endtask : ext_chk

  // three start-up configurations; required memory programming and trigger routing tested in the first only
  initial begin
    int          c, i;
    logic        mod8, a32, ok;
    logic [2:0]  ln, l2;
    logic [5:0]  slots;
    logic [7:0]  sw;
    logic [15:0] off;
    logic [31:0] base, half;
    sys_clk = 1'b0;
    rst = 1'b1;
    laSwitch = 8'h80;
    moduloSelect = 1'b0;
    slotSwitch = 6'h00;
    identValid = 6'h04;
    identReqMem = 24'h000C00;
    a16Addr = 8'h00;
    extAddr = 32'h0;
    bpLine = 8'h00;
    modTrigOut = 12'h000;
    badCount = 0;
    totalChecks = 0;
    void'($urandom(99));
    for (c = 0; c < 3; c++) begin
      mod8 = (c != 0);
      a32 = (c == 1);
      sw = (c == 0) ? {3'h4, 5'($urandom) | 5'h10}
                    : {~a32, 5'h00, 1'b1, c == 2};
      // first pass keeps B on; second pass disables D and E
      slots = (c == 1) ? 6'h18
                       : 6'($urandom) & ((c == 0) ? 6'h38 : 6'h3A);
      boot(sw, mod8, slots);
      a16_chk(sw, mod8, slots);
      xfer(1'b0, 3'h0, OFS_DEVTYPE, {a32 ? 4'hF : 4'hE, MODEL_CODE});
      xfer(1'b0, 3'h2, OFS_DEVTYPE, {4'hC, MODEL_CODE});
      xfer(1'b0, 3'h0, OFS_STATUS, 16'h7FFC);
      xfer(1'b0, 3'h0, OFS_TRIG, 16'h0000);
      xfer(1'b0, 3'h6, OFS_TRIG, 16'h0000);
      xfer(1'b0, 3'h0, 8'h10, 16'h0000);
      check(32'(ttlTrigOe), 32'h0);
      off = 16'($urandom) & 16'h7FFE;
      base = a32 ? {off, 16'h0000} : {8'h00, off, 8'h00};
      half = a32 ? 32'h8000 : 32'h0100;
      xfer(1'b1, 3'h0, OFS_OFFSET, off);
      ext_chk(base + 32'h10, 6'h00, 1'b0, 1'b0, 32'h0);
      xfer(1'b1, 3'h0, OFS_STATUS, 16'h8000);
      xfer(1'b0, 3'h0, OFS_STATUS, 16'hFFFC);
      ext_chk(base + 32'h10, 6'h01, 1'b1, 1'b0, 32'h10);
      ext_chk(base + half, 6'h01, 1'b0, 1'b1, half);
      ext_chk(base + 2 * half, 6'h00, 1'b0, 1'b0, 32'h0);
      if (c == 0) begin
        u_ctrl.set_reqmem(3'h0, 512 * 1024, a32, ok);
        check({30'h0, ok, nvReady}, 32'h2);
        xfer(1'b0, 3'h0, OFS_DEVTYPE, {4'h3, MODEL_CODE});
        ext_chk(base + half, 6'h01, 1'b0, 1'b1, half);
        ln = 3'($urandom);
        l2 = ln + 3'h1;
        xfer(1'b1, 3'h0, OFS_TRIG, {3'h5, 2'h3, l2, 3'h6, 2'h3, ln});
        xfer(1'b1, 3'h1, OFS_TRIG_ALT, {3'h2,2'h0,l2,3'h7,2'h0,ln});
        xfer(1'b0, 3'h0, OFS_TRIG_ALT, {3'h5,2'h0,l2,3'h6,2'h0,ln});
        for (i = 0; i < 8; i++) begin
          @(posedge sys_clk);
          modTrigOut <= 12'($urandom);
          bpLine <= 8'($urandom);
          repeat (4) @(posedge sys_clk);
          check(32'(ttlTrigOe), 32'(8'h01 << ln));
          check(32'((modTrigOut[0] | ~modTrigOut[2]) ? 8'h01 << ln : 8'h00),
                32'(ttlTrigOut));
          check(32'(modTrigIn), 32'({~bpLine[l2], 1'b0}));
        end
      end
    end
    conclude();
  end

  // cut a hang short
  initial begin
    repeat (100000) @(posedge sys_clk);
    badCount++;
    conclude();
  end
endmodule : module_carrier_slot_config_test
